/* File: rtl/res_pkg.sv */
// Package for the reading and error store block
package res_pkg;
  // APB register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_RDG = 8'h08;
  localparam logic [7:0] OFF_CNT = 8'h0c;
  localparam logic [7:0] OFF_ERR = 8'h10;
  localparam logic [7:0] OFF_ERRPUSH = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_MSG = 8'h1c;
  localparam logic [7:0] OFF_TST = 8'h20;
  // CTRL bit positions
  localparam int CTRL_STORE = 0;
  localparam int CTRL_DISP = 1;
  localparam int CTRL_MENU = 2;
  localparam int CTRL_RECALL = 3;
  // CMD bit positions (write-one pulses)
  localparam int CMD_CLS = 0;
  localparam int CMD_RIRST = 1;
  localparam int CMD_MSGCLR = 2;
  localparam int CMD_SELFTEST = 3;
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h2;
  // Error codes
  localparam logic [15:0] ERR_OVERFLOW = 16'hfea2;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_SELFTEST = 16'hfeea;
  // Timing
  localparam longint KEY_HOLD_NS = 64'd5000000000;
  localparam longint CLK_NS = 64'd10;
  localparam longint KEY_HOLD_CYC = (KEY_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MSG_MAX = 11;
  localparam int ERR_TEXT_MAX = 80;
  localparam int ST_RESULTS = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CLEAR = 2'b01,
    ST_WRITE = 2'b10,
    ST_DONE = 2'b11
  } res_st_e;

  typedef struct packed {
    logic valid;
    logic [31:0] value;
  } res_rdg_s;

  typedef struct packed {
    logic [15:0] code;
    logic [7:0] text_id;
  } res_err_s;
endpackage

/* File: rtl/res_store.sv */
// Reading memory, error queue, self-test and display control
//
// Behaviour
// - Reading memory holds up to 1024 readings
// - Readings come out oldest first
// - Only the reading value is stored
// - Memory empties on enable, reset, self-test
// - Each trigger stores sample-count readings
// - Recall view turns storage off
// - Twenty-entry error queue, indicator when nonempty
// - Errors oldest first, indicator clears empty
// - One beep per queued error
// - Overflow code replaces newest, then blocks
// - Empty queue read returns zero, unchanged
// - Error queue clears on reset, clear-status
// - Error is 16-bit code only, no text
// - Self-test clears memory, stores results only
// - Self-test shows pass or fail, error
// - Self-test query answers zero or one
// - Shift held five seconds from power-on starts self-test on release
// - Display off blocks readings, most indicators
// - Display enable volatile, on after reset
// - Eleven message characters, punctuation shares place
// - Message shows when display off, blocks readings
// - Menu forces display on
`timescale 1ns/100ps
`default_nettype none
module res_store #(
  parameter int DEPTH = 1024,
  parameter int EDEPTH = 20,
  parameter longint HOLD_CYC = res_pkg::KEY_HOLD_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement engine
  input wire res_pkg::res_rdg_s rdg_in,
  input wire logic trig_acc,
  input wire logic [15:0] sample_cnt,
  input wire logic st_fail,
  // Front panel
  input wire logic shift_key,
  input wire logic power_on,
  output logic [31:0] disp_value,
  output logic disp_update,
  output logic [7:0] annunc,
  output logic err_led,
  output logic beep,
  output logic msg_on,
  output logic [3:0] msg_len,
  output logic st_pass_ind,
  output logic st_fail_ind
);
  localparam int AW = $clog2(DEPTH);
  localparam int EW = $clog2(EDEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    $error("DEPTH must be a power of two");
  if (EDEPTH < 2)
    $error("EDEPTH too small");

  logic [31:0] mem [DEPTH];
  logic [15:0] eq [EDEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic [EW-1:0] ewp_q, erp_q;
  logic [EW:0] ecnt_q;
  logic ovf_q;
  logic [3:0] ctrl_q;
  logic [15:0] burst_q;
  logic msg_q;
  logic [3:0] mlen_q;
  logic st_res_q, st_busy_q;
  res_pkg::res_st_e st_q;
  logic [2:0] st_n_q;
  logic [2:0] key_s_q;
  logic [63:0] hold_q;
  logic held_q, key_armed_q;

  // Decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire a_ctrl = paddr == res_pkg::OFF_CTRL;
  wire a_stat = paddr == res_pkg::OFF_STAT;
  wire a_rdg = paddr == res_pkg::OFF_RDG;
  wire a_cnt = paddr == res_pkg::OFF_CNT;
  wire a_err = paddr == res_pkg::OFF_ERR;
  wire a_epush = paddr == res_pkg::OFF_ERRPUSH;
  wire a_cmd = paddr == res_pkg::OFF_CMD;
  wire a_msg = paddr == res_pkg::OFF_MSG;
  wire a_tst = paddr == res_pkg::OFF_TST;
  wire mapped = a_ctrl | a_stat | a_rdg | a_cnt | a_err | a_epush | a_cmd
    | a_msg | a_tst;
  wire cmd_cls = wr && a_cmd && pwdata[res_pkg::CMD_CLS];
  wire cmd_rst = wr && a_cmd && pwdata[res_pkg::CMD_RIRST];
  wire cmd_mclr = wr && a_cmd && pwdata[res_pkg::CMD_MSGCLR];
  wire cmd_st = wr && a_cmd && pwdata[res_pkg::CMD_SELFTEST];
  wire q_tst = rd && a_tst;

  // Key synchroniser: change counts once stages two and three agree
  wire key_lvl = key_s_q[1] & key_s_q[2];
  wire key_rel = held_q && !key_s_q[1] && !key_s_q[2];
  wire st_start = (cmd_st || q_tst || key_rel) && !st_busy_q;

  // Storage enable and recall handling
  wire store_on_wr = wr && a_ctrl && pwdata[res_pkg::CTRL_STORE]
    && !ctrl_q[res_pkg::CTRL_STORE];
  wire recall_go = wr && a_ctrl && pwdata[res_pkg::CTRL_RECALL];
  wire mem_clr = store_on_wr || cmd_rst || st_start;
  wire store_en = ctrl_q[res_pkg::CTRL_STORE] && !st_busy_q;
  wire burst_any = trig_acc || burst_q != 16'h0000;
  wire rdg_push = store_en && rdg_in.valid && burst_any
    && cnt_q != (AW+1)'(DEPTH);
  wire st_push = st_q == res_pkg::ST_WRITE && cnt_q != (AW+1)'(DEPTH);
  wire push = rdg_push || st_push;
  wire [31:0] push_val = st_push ? {29'h0, st_n_q} ^ {31'h0, st_res_q}
    : rdg_in.value;
  wire pop = rd && a_rdg && cnt_q != '0;

  // Error queue
  wire e_full = ecnt_q == (EW+1)'(EDEPTH);
  wire e_pop = rd && a_err && ecnt_q != '0;
  wire st_err = st_q == res_pkg::ST_DONE && st_res_q;
  wire e_in = (wr && a_epush) || st_err;
  wire [15:0] e_code = st_err ? res_pkg::ERR_SELFTEST : pwdata[15:0];
  wire e_push = e_in && !ovf_q && (!e_full || e_pop);
  wire e_ovf = e_in && !ovf_q && e_full && !e_pop;
  wire e_clr = cmd_cls || cmd_rst;
  wire [EW-1:0] ewp_last = ewp_q == '0 ? EW'(EDEPTH - 1) : ewp_q - 1'b1;

  function automatic logic [EW-1:0] einc(input logic [EW-1:0] p);
    return p == EW'(EDEPTH - 1) ? '0 : p + 1'b1;
  endfunction

  // Display
  wire disp_en = ctrl_q[res_pkg::CTRL_DISP] || ctrl_q[res_pkg::CTRL_MENU];
  wire [7:0] ch = pwdata[7:0];
  wire punct = ch == 8'h2c || ch == 8'h2e || ch == 8'h3b;
  wire msg_start = wr && a_msg && pwdata[31];

  wire [31:0] rd_mux =
    a_ctrl ? {28'h0, ctrl_q} :
    a_stat ? {24'h0, msg_q, st_busy_q, st_res_q, ovf_q, err_led,
      cnt_q == '0, 2'b00} :
    a_rdg ? (cnt_q != '0 ? mem[rp_q] : 32'h0) :
    a_cnt ? {{(31-AW){1'b0}}, cnt_q} :
    a_err ? (ecnt_q != '0 ? {16'h0, eq[erp_q]}
      : {16'h0, res_pkg::ERR_NONE}) :
    a_msg ? {28'h0, mlen_q} :
    a_tst ? {31'h0, st_res_q} : 32'h0;

  // Reading memory
  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wp_q] <= push_val;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (mem_clr)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q <= push ? wp_q + 1'b1 : wp_q;
      rp_q <= pop ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Burst counter for sample count per trigger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      burst_q <= '0;
    else if (trig_acc)
      burst_q <= rdg_in.valid ? sample_cnt - 16'h1 : sample_cnt;
    else if (rdg_in.valid && burst_q != 16'h0000)
      burst_q <= burst_q - 16'h1;
  end

  // Error queue storage
  always_ff @(posedge pclk)
  begin
    if (e_push)
      eq[ewp_q] <= e_code;
    else if (e_ovf)
      eq[ewp_last] <= res_pkg::ERR_OVERFLOW;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ewp_q <= '0;
      erp_q <= '0;
      ecnt_q <= '0;
      ovf_q <= 1'b0;
    end
    else if (e_clr)
    begin
      ewp_q <= '0;
      erp_q <= '0;
      ecnt_q <= '0;
      ovf_q <= 1'b0;
    end
    else
    begin
      ewp_q <= e_push ? einc(ewp_q) : ewp_q;
      erp_q <= e_pop ? einc(erp_q) : erp_q;
      ecnt_q <= ecnt_q + (EW+1)'(e_push) - (EW+1)'(e_pop);
      if (e_ovf)
        ovf_q <= 1'b1;
      else if (e_pop)
        ovf_q <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= res_pkg::CTRL_RST;
    else if (cmd_rst)
      ctrl_q <= res_pkg::CTRL_RST;
    else if (wr && a_ctrl)
    begin
      ctrl_q <= pwdata[3:0];
      if (recall_go)
        ctrl_q[res_pkg::CTRL_STORE] <= 1'b0;
    end
  end

  // Message override
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msg_q <= 1'b0;
      mlen_q <= '0;
    end
    else if (cmd_mclr || cmd_rst)
    begin
      msg_q <= 1'b0;
      mlen_q <= '0;
    end
    else if (wr && a_msg)
    begin
      msg_q <= 1'b1;
      if (msg_start)
        mlen_q <= punct ? 4'h1 : 4'h1;
      else if (!(punct && mlen_q != '0)
        && mlen_q != 4'(res_pkg::MSG_MAX))
        mlen_q <= mlen_q + 4'h1;
    end
  end

  // Self-test sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= res_pkg::ST_IDLE;
      st_n_q <= '0;
      st_res_q <= 1'b0;
      st_busy_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        res_pkg::ST_IDLE:
          if (st_start)
          begin
            st_q <= res_pkg::ST_CLEAR;
            st_busy_q <= 1'b1;
            st_res_q <= st_fail;
          end
        res_pkg::ST_CLEAR:
        begin
          st_q <= res_pkg::ST_WRITE;
          st_n_q <= '0;
        end
        res_pkg::ST_WRITE:
        begin
          st_n_q <= st_n_q + 3'h1;
          if (st_n_q == 3'(res_pkg::ST_RESULTS - 1))
            st_q <= res_pkg::ST_DONE;
        end
        default:
        begin
          st_q <= res_pkg::ST_IDLE;
          st_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Power-on shift hold timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_s_q <= '0;
      hold_q <= '0;
      held_q <= 1'b0;
      key_armed_q <= 1'b0;
    end
    else
    begin
      key_s_q <= {key_s_q[1:0], shift_key};
      if (power_on)
        key_armed_q <= 1'b1;
      else if (key_s_q[2:1] == 2'b00 && !held_q)
        key_armed_q <= 1'b0;
      if (key_armed_q && key_lvl && !held_q)
      begin
        hold_q <= hold_q + 64'h1;
        if (hold_q >= HOLD_CYC)
          held_q <= 1'b1;
      end
      else if (key_rel)
        held_q <= 1'b0;
      else if (key_s_q[2:1] == 2'b00)
        hold_q <= '0;
    end
  end

  // Outputs and APB answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      disp_value <= '0;
      disp_update <= 1'b0;
      annunc <= '0;
      err_led <= 1'b0;
      beep <= 1'b0;
      msg_on <= 1'b0;
      msg_len <= '0;
      st_pass_ind <= 1'b0;
      st_fail_ind <= 1'b0;
    end
    else
    begin
      pready <= psel && !pready;
      prdata <= psel && !pready ? rd_mux : prdata;
      pslverr <= psel && !pready && !mapped;
      disp_update <= rdg_in.valid && disp_en && !msg_q;
      if (rdg_in.valid && disp_en && !msg_q)
        disp_value <= rdg_in.value;
      annunc <= disp_en ? {ctrl_q[res_pkg::CTRL_STORE], 7'h7f}
        : 8'h03;
      err_led <= ecnt_q != '0 || e_push || e_ovf;
      beep <= e_push;
      msg_on <= msg_q;
      msg_len <= mlen_q;
      if (st_q == res_pkg::ST_DONE)
      begin
        st_pass_ind <= !st_res_q;
        st_fail_ind <= st_res_q;
      end
      else if (st_start)
      begin
        st_pass_ind <= 1'b0;
        st_fail_ind <= 1'b0;
      end
    end
  end
endmodule // res_store
`default_nettype wire

/* File: testbench/res_store_monitor.sv */
// Port checker for the reading and error store
`timescale 1ns/100ps
`default_nettype none
module res_store_monitor #(
  parameter int DEPTH = 1024
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Panel
  input wire logic disp_update,
  input wire logic err_led,
  input wire logic beep,
  input wire logic msg_on,
  input wire logic [3:0] msg_len,
  input wire logic st_pass_ind,
  input wire logic st_fail_ind
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic rd_ok = psel && penable && pready && !pwrite;
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_count_max: assert property (
    rd_ok && paddr == res_pkg::OFF_CNT |-> prdata <= DEPTH)
    else $error("count above depth");
  a_empty_pop: assert property (
    rd_ok && paddr == res_pkg::OFF_ERR && !err_led |-> prdata == 32'h0)
    else $error("empty queue read not zero");
  a_beep_pulse: assert property (beep |=> !beep)
    else $error("beep held");
  a_msg_blocks: assert property (msg_on |-> !disp_update)
    else $error("reading shown over message");
  a_msg_len: assert property (msg_len <= 4'hb)
    else $error("message too long");
  a_ind_excl: assert property (!(st_pass_ind && st_fail_ind))
    else $error("pass and fail together");
  a_fail_led: assert property ($rose(st_fail_ind) |-> ##[0:4] err_led)
    else $error("fail without error light");
endmodule // res_store_monitor
bind res_store res_store_monitor #(.DEPTH(DEPTH)) u_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .disp_update, .err_led, .beep, .msg_on, .msg_len,
  .st_pass_ind, .st_fail_ind
);
`default_nettype wire

/* File: testbench/res_meas_model.sv */
// Measurement engine model: readings per trigger
`timescale 1ns/100ps
`default_nettype none
module res_meas_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Trigger
  input wire logic trig_acc,
  input wire logic [15:0] sample_cnt,
  // Readings
  output var res_pkg::res_rdg_s rdg
);
  logic [15:0] left_q;
  logic [31:0] val_q;
  // One reading every other cycle, value flips when idle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      left_q <= 16'h0;
      val_q <= 32'h100;
      rdg <= '0;
    end
    else if (trig_acc)
    begin
      left_q <= sample_cnt;
      rdg <= '{1'b0, ~rdg.value};
    end
    else if (left_q != 16'h0 && !rdg.valid)
    begin
      left_q <= left_q - 16'h1;
      rdg <= '{1'b1, val_q};
      val_q <= val_q + 32'h1;
    end
    else
      rdg <= '{1'b0, ~rdg.value};
endmodule // res_meas_model
`default_nettype wire

/* File: testbench/tb_reading_and_error_store.sv */
// Bench for the reading and error store
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_reading_and_error_store;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic trig_acc, st_fail, shift_key, power_on, disp_update, err_led;
  logic beep, msg_on, st_pass_ind, st_fail_ind;
  logic [7:0] paddr, annunc;
  logic [31:0] pwdata, prdata, disp_value, rd, nxt, c;
  logic [15:0] sample_cnt;
  logic [3:0] msg_len;
  res_pkg::res_rdg_s rdg;
  int err_total, n_tests, beeps, upds;

  res_store #(.HOLD_CYC(20)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rdg_in(rdg), .trig_acc, .sample_cnt, .st_fail,
    .shift_key, .power_on, .disp_value, .disp_update, .annunc, .err_led,
    .beep, .msg_on, .msg_len, .st_pass_ind, .st_fail_ind
  );
  res_meas_model MEAS (.pclk, .presetn, .trig_acc, .sample_cnt, .rdg);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (beep === 1'b1) beeps++;
    if (disp_update === 1'b1) upds++;
  end

  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic get(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic trig(input logic [15:0] n);
    @(posedge pclk);
    sample_cnt <= n;
    trig_acc <= 1'b1;
    @(posedge pclk);
    trig_acc <= 1'b0;
    repeat (2 * n + 6) @(posedge pclk);
    nxt = nxt + n;
    #1;
  endtask
  task automatic st_wait(input logic f);
    int n;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((f ? st_fail_ind : st_pass_ind) !== 1'b1 && n < 5000);
    #1;
    `CHK(n < 5000, 1'b1)
  endtask

  initial
  begin
    {psel, penable, pwrite, trig_acc, st_fail, shift_key, power_on} = '0;
    {paddr, pwdata, sample_cnt} = '0;
    {err_total, n_tests, beeps, upds} = '0;
    nxt = 32'h100;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    get(res_pkg::OFF_CTRL);
    `CHK(rd[3:0], res_pkg::CTRL_RST)
    get(8'h40);
    `CHK(perr, 1'b1)
    wr(res_pkg::OFF_CTRL, 32'h3);
    trig(3);
    get(res_pkg::OFF_CNT);
    `CHK(rd, 32'h3)
    for (int i = 3; i > 0; i--)
    begin
      get(res_pkg::OFF_RDG);
      `CHK(rd, nxt - i)
    end
    trig(2);
    wr(res_pkg::OFF_CTRL, 32'h2);
    wr(res_pkg::OFF_CTRL, 32'h3);
    get(res_pkg::OFF_CNT);
    `CHK(rd, 32'h0)
    trig(2);
    wr(res_pkg::OFF_CMD, 32'h1 << res_pkg::CMD_RIRST);
    get(res_pkg::OFF_CNT);
    `CHK(rd, 32'h0)
    get(res_pkg::OFF_CTRL);
    `CHK(rd[3:0], res_pkg::CTRL_RST)
    wr(res_pkg::OFF_CTRL, 32'h1);
    upds = 0;
    trig(1);
    `CHK(upds, 0)
    `CHK(annunc[7:2], 6'h0)
    wr(res_pkg::OFF_CTRL, 32'h5);
    trig(1);
    `CHK(upds, 1)
    wr(res_pkg::OFF_CTRL, 32'h3);
    trig(1);
    `CHK(upds, 2)
    `CHK(disp_value, nxt - 32'h1)
    wr(res_pkg::OFF_CTRL, 32'h1);
    wr(res_pkg::OFF_MSG, 32'h8000_0041);
    wr(res_pkg::OFF_MSG, 32'h2c);
    `CHK(msg_on, 1'b1)
    get(res_pkg::OFF_MSG);
    `CHK(rd[3:0], 4'h1)
    for (int i = 0; i < 12; i++)
      wr(res_pkg::OFF_MSG, 32'h42);
    get(res_pkg::OFF_MSG);
    `CHK(rd[3:0], 4'hb)
    `CHK(msg_len, 4'hb)
    wr(res_pkg::OFF_CTRL, 32'h3);
    upds = 0;
    trig(1);
    `CHK(upds, 0)
    wr(res_pkg::OFF_CMD, 32'h1 << res_pkg::CMD_MSGCLR);
    trig(1);
    `CHK(msg_on, 1'b0)
    `CHK(upds, 1)
    get(res_pkg::OFF_CNT);
    c = rd;
    wr(res_pkg::OFF_CTRL, 32'hb);
    trig(1);
    get(res_pkg::OFF_CNT);
    `CHK(rd, c)
    beeps = 0;
    for (int i = 1; i < 21; i++)
      wr(res_pkg::OFF_ERRPUSH, i);
    @(posedge pclk);
    #1;
    `CHK(beeps, 20)
    `CHK(err_led, 1'b1)
    for (int i = 21; i < 23; i++)
      wr(res_pkg::OFF_ERRPUSH, i);
    for (int i = 1; i < 20; i++)
    begin
      get(res_pkg::OFF_ERR);
      `CHK(rd[15:0], 16'(i))
    end
    get(res_pkg::OFF_ERR);
    `CHK(rd[15:0], res_pkg::ERR_OVERFLOW)
    get(res_pkg::OFF_ERR);
    `CHK(rd, 32'h0)
    `CHK(err_led, 1'b0)
    wr(res_pkg::OFF_ERRPUSH, 32'h5);
    wr(res_pkg::OFF_CMD, 32'h1 << res_pkg::CMD_CLS);
    get(res_pkg::OFF_ERR);
    `CHK(rd, 32'h0)
    `CHK(err_led, 1'b0)
    get(res_pkg::OFF_CTRL);
    c = rd;
    @(posedge pclk);
    st_fail <= 1'b1;
    wr(res_pkg::OFF_CMD, 32'h1 << res_pkg::CMD_SELFTEST);
    st_wait(1'b1);
    get(res_pkg::OFF_CNT);
    `CHK(rd, 32'(res_pkg::ST_RESULTS))
    `CHK(err_led, 1'b1)
    get(res_pkg::OFF_CTRL);
    `CHK(rd, c)
    get(res_pkg::OFF_ERR);
    `CHK(rd[15:0], res_pkg::ERR_SELFTEST)
    @(posedge pclk);
    st_fail <= 1'b0;
    get(res_pkg::OFF_TST);
    `CHK(rd[0], 1'b1)
    st_wait(1'b0);
    @(posedge pclk);
    st_fail <= 1'b1;
    shift_key <= 1'b1;
    repeat (4) @(posedge pclk);
    power_on <= 1'b1;
    @(posedge pclk);
    power_on <= 1'b0;
    repeat (40) @(posedge pclk);
    `CHK(st_pass_ind, 1'b1)
    shift_key <= 1'b0;
    st_wait(1'b1);
    @(posedge pclk);
    st_fail <= 1'b0;
    get(res_pkg::OFF_TST);
    st_wait(1'b0);
    get(res_pkg::OFF_TST);
    `CHK(rd[0], 1'b0)
    wrap_up();
  end

  initial
  begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule // tb_reading_and_error_store
`undef CHK
`default_nettype wire
